// file: verilog/lram_cfg.svh
`ifndef LRAM_CFG_SVH
`define LRAM_CFG_SVH

// Register byte offsets
`define LRAM_CFG_OFF 32'h0000_0000
`define LRAM_STAT_OFF 32'h0000_0004

// Configuration word width and reset value
`define LRAM_CFG_W 15
`define LRAM_CFG_RST 15'h0000

// Width code of the 144-bit shape; codes above it are illegal
`define LRAM_W144 3'h4

// FIFO capacity in 9-bit lanes
`define LRAM_FIFO_CAP 17'h1_0000

// Status field positions
`define LRAM_ST_EMPTY 17
`define LRAM_ST_FULL 18
`define LRAM_ST_REJ 19

// AXI responses
`define LRAM_RESP_OK 2'h0
`define LRAM_RESP_SLV 2'h2

`endif

// file: verilog/lram_pkg.sv
package lram_pkg;

  // Operating mode of the array
  typedef enum logic [1:0]
  {
    LRAM_TDP = 2'h0,
    LRAM_SDP = 2'h1,
    LRAM_SP = 2'h2,
    LRAM_FIFO = 2'h3
  } lram_mode_t;

  // Configuration register layout, MSB first
  typedef struct packed {
    logic out_sel_b;
    logic in_sel_b;
    logic out_sel_a;
    logic in_sel_a;
    logic byte8;
    logic outreg_b;
    logic outreg_a;
    logic [2:0] width_b;
    logic [2:0] width_a;
    lram_mode_t mode;
  } lram_cfg_t;

  // One port's request: write-select, address, data, lane mask
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [71:0] din;
    logic [7:0] mask;
  } lram_req_t;

endpackage

// file: verilog/lram_port_reg.sv
`timescale 1ns/1ps
module lram_port_reg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clr,
  input wire logic en,
  input wire logic byte8,
  input wire lram_pkg::lram_req_t req,
  output lram_pkg::lram_req_t req_q,
  output logic go_q
);

  logic [71:0] din_x;

  // 8-bit lanes are spread onto 9-bit lanes with the ninth bit zero
  for (genvar i = 0; i < 8; i++)
  begin : g_lane
    assign din_x[9*i+:9] = byte8 ? {1'b0, req.din[8*i+:8]}
                                 : req.din[9*i+:9]; // [RULE16]
  end

  // Every input is captured before the array sees it; clear is immediate
  always_ff @(posedge aclk or posedge clr)
  begin
    if (clr)
    begin
      req_q <= '0;
      go_q <= 1'b0; // [RULE24]
    end
    else if (!aresetn)
    begin
      req_q <= '0;
      go_q <= 1'b0;
    end
    else
    begin
      go_q <= en; // [RULE4]
      if (en)
        req_q <= {req.we, req.addr, din_x, req.mask}; // [RULE4]
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || clr);

  go_follow_a: assert property (##1 go_q == $past(en)) // [RULE4]
    else $error("go does not follow the enable");
  din_pad_a: assert property (en && byte8 |=> // [RULE16]
    req_q.din[8] == 1'b0 && req_q.din[7:0] == $past(req.din[7:0]))
    else $error("8-bit lane not spread onto 9-bit lane");

endmodule // lram_port_reg

// file: verilog/lram_top.sv
// Functional notes
// (RULE1) Array holds 589,824 bits: 4096 rows of sixteen 9-bit lanes.
// (RULE2) Modes: true dual-port, simple dual-port, single-port, FIFO.
// (RULE3) No preload; contents undefined until written.
// (RULE4) Every port input is registered before use.
// (RULE5) Output register optional; bypass takes data straight from array.
// (RULE6) Shapes 64Kx9, 32Kx18, 16Kx36, 8Kx72, 4Kx144 and 8-bit variants.
// (RULE7) 144-bit shape never allowed in true dual-port mode.
// (RULE8) Simple dual-port widths free among 9..72; 144 pairs only with 144.
// (RULE9) True dual-port ports each pick 9, 18, 36 or 72 freely.
// (RULE10) Write-select high writes, low reads; no read enable exists.
// (RULE11) Lane stored only when write-select and its mask bit are high.
// (RULE12) Masks exist for 18, 36, 72 widths: 2, 4, 8 bits.
// (RULE13) Mask bit i covers data bits 9i+8 down to 9i.
// (RULE14) 144-bit shape joins both masks into 16; bit 15 covers 143..135.
// (RULE15) Any mask combination; unmasked lanes keep old contents.
// (RULE16) 8-bit data widths mask identically on 8-bit lanes.
// (RULE17) A port's input registers share one of the two port clocks.
// (RULE18) User logic drives clock, enable, clear, write-select per port.
// (RULE19) Each port has 72 data inputs and 72 data outputs.
// (RULE20) Independent mode: each port's registers run on its own clock.
// (RULE21) Read/write mode: write side and read side clock separately.
// (RULE22) Input/output mode: output register may use the other clock.
// (RULE23) User avoids dual writes to one address in true dual-port mode.
// (RULE24) Clear resets port registers at once, leaving the array alone.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "lram_cfg.svh"
module lram_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic cen_a,
  input wire logic clr_a,
  input wire lram_pkg::lram_req_t req_a,
  output logic [71:0] dout_a,
  input wire logic cen_b,
  input wire logic clr_b,
  input wire lram_pkg::lram_req_t req_b,
  output logic [71:0] dout_b
);

  ////////////////////////////////////////////////////////////////////////
  // Register slave

  lram_pkg::lram_cfg_t cfg_q;
  lram_pkg::lram_cfg_t cand;
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
  logic arready_q, rvalid_q, rej_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q, cfg_new, stat_word;
  logic [3:0] wstrb_q;
  logic [16:0] cnt_q;
  logic [15:0] wptr_q, rptr_q;

  // Merge strobed bytes into the current configuration
  for (genvar k = 0; k < 4; k++)
  begin : g_strb
    assign cfg_new[8*k+:8] = wstrb_q[k] ? wdata_q[8*k+:8]
                                        : 8'(32'(cfg_q) >> (8*k));
  end
  assign cand = cfg_new[`LRAM_CFG_W-1:0];

  // Shape legality is checked before a configuration is accepted
  wire cand_wa = cand.width_a == `LRAM_W144;
  wire cand_wb = cand.width_b == `LRAM_W144;
  wire cand_bad = cand.width_a > `LRAM_W144 || cand.width_b > `LRAM_W144;
  wire cand_ok = !cand_bad &&
    (cand.mode == lram_pkg::LRAM_TDP ? !cand_wa && !cand_wb : // [RULE7]
     cand.mode == lram_pkg::LRAM_SP ? 1'b1 : // [RULE9]
     cand_wa == cand_wb); // [RULE8]

  // Address decode on whole words
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire wr_cfg = {awaddr_q[31:2], 2'h0} == `LRAM_CFG_OFF;
  wire wr_st = {awaddr_q[31:2], 2'h0} == `LRAM_STAT_OFF;
  wire cfg_load = wr_go && wr_cfg && cand_ok;
  wire wr_ok = wr_st || cfg_load;
  wire rd_cfg = {araddr[31:2], 2'h0} == `LRAM_CFG_OFF;
  wire rd_st = {araddr[31:2], 2'h0} == `LRAM_STAT_OFF;

  assign stat_word = {12'h000, rej_q, cnt_q == `LRAM_FIFO_CAP,
                      cnt_q == 17'h0, cnt_q};

  // Write channel: address and data taken in either order, then answered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `LRAM_RESP_OK;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      cfg_q <= `LRAM_CFG_RST;
      rej_q <= 1'b0;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q)
      begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `LRAM_RESP_OK : `LRAM_RESP_SLV;
        if (wr_cfg)
          rej_q <= !cand_ok;
        if (cfg_load)
          cfg_q <= cand;
      end
      if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `LRAM_RESP_OK;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_cfg ? 32'(cfg_q) : rd_st ? stat_word : 32'h0000_0000;
      rresp_q <= rd_cfg || rd_st ? `LRAM_RESP_OK : `LRAM_RESP_SLV;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////
  // Port input stages

  lram_pkg::lram_req_t rq_a, rq_b;
  logic go_a, go_b;

  // Each register group follows the enable of the clock chosen for it
  wire in_en_a = cfg_q.in_sel_a ? cen_b : cen_a; // [RULE17] [RULE18]
  wire in_en_b = cfg_q.in_sel_b ? cen_a : cen_b; // [RULE20] [RULE21]
  wire out_en_a = cfg_q.out_sel_a ? cen_b : cen_a; // [RULE22]
  wire out_en_b = cfg_q.out_sel_b ? cen_a : cen_b; // [RULE22]

  lram_port_reg u_port_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clr_a),
    .en(in_en_a),
    .byte8(cfg_q.byte8),
    .req(req_a),
    .req_q(rq_a),
    .go_q(go_a)
  );

  lram_port_reg u_port_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clr_b),
    .en(in_en_b),
    .byte8(cfg_q.byte8),
    .req(req_b),
    .req_q(rq_b),
    .go_q(go_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // Lane addressing and write control

  wire is_tdp = cfg_q.mode == lram_pkg::LRAM_TDP;
  wire is_sp = cfg_q.mode == lram_pkg::LRAM_SP;
  wire is_fifo = cfg_q.mode == lram_pkg::LRAM_FIFO;
  wire w144 = cfg_q.width_a == `LRAM_W144;
  wire [4:0] nl_a = 5'(5'h1 << cfg_q.width_a);
  wire [4:0] nl_b = 5'(5'h1 << cfg_q.width_b);

  // FIFO occupancy in lanes; mixed widths move different lane counts
  wire full_a = (cnt_q + 17'(nl_a)) > `LRAM_FIFO_CAP;
  wire empty_b = cnt_q < 17'(nl_b);
  wire push = is_fifo && go_a && rq_a.we && !full_a; // [RULE2]
  wire pop = is_fifo && go_b && !rq_b.we && !empty_b; // [RULE2]

  // Port address counts words of the port's width; depth follows width
  wire [15:0] lidx_a = is_fifo ? wptr_q
                               : 16'(rq_a.addr << cfg_q.width_a); // [RULE6]
  wire [15:0] lidx_b = is_fifo ? rptr_q
                               : 16'(rq_b.addr << cfg_q.width_b); // [RULE6]
  wire [11:0] row_a = lidx_a[15:4];
  wire [11:0] row_b = lidx_b[15:4];
  wire [7:0] sh_a = 8'(lidx_a[3:0]) * 8'h09;
  wire [7:0] sh_b = 8'(lidx_b[3:0]) * 8'h09;

  // The 9-bit width has no mask: lanes follow write-select alone
  wire [7:0] mk_a = cfg_q.width_a == 3'h0 ? 8'hff : rq_a.mask; // [RULE12]
  wire [7:0] mk_b = cfg_q.width_b == 3'h0 ? 8'hff : rq_b.mask; // [RULE12]
  wire [15:0] lm_a = 16'((17'h1 << nl_a) - 17'h1) & {8'h00, mk_a};
  wire [15:0] lm_b = 16'((17'h1 << nl_b) - 17'h1) & {8'h00, mk_b};

  // Mask bit i steers lane i; the wide shape joins both masks
  wire [15:0] le_a = w144 ? {mk_b, mk_a}
                          : 16'(lm_a << lidx_a[3:0]); // [RULE13] [RULE14]
  wire [15:0] le_b = 16'(lm_b << lidx_b[3:0]); // [RULE13]
  wire [143:0] wd_a = w144 ? {rq_b.din, rq_a.din}
                           : 144'(144'(rq_a.din) << sh_a); // [RULE19]
  wire [143:0] wd_b = 144'(144'(rq_b.din) << sh_b);

  // Port B writes only in true dual-port mode; it reads otherwise
  wire wr_a = go_a && rq_a.we && (!is_fifo || !full_a); // [RULE10]
  wire wr_b = go_b && rq_b.we && is_tdp; // [RULE10]

  ////////////////////////////////////////////////////////////////////////
  // Storage array

  logic [143:0] mem [0:4095]; // [RULE1]

  // No reset and no preload. On a same-address dual write port A's lane
  // lands last; the outcome is left to the user to avoid.
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (wr_b && le_b[i]) // [RULE11] [RULE15] [RULE23]
        mem[row_b][9*i+:9] <= wd_b[9*i+:9];
      if (wr_a && le_a[i]) // [RULE11] [RULE15] [RULE3]
        mem[row_a][9*i+:9] <= wd_a[9*i+:9];
    end
  end

  // FIFO pointers restart whenever a new configuration is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cfg_load)
    begin
      wptr_q <= 16'h0000;
      rptr_q <= 16'h0000;
      cnt_q <= 17'h0_0000;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + 16'(nl_a);
      if (pop)
        rptr_q <= rptr_q + 16'(nl_b);
      cnt_q <= cnt_q + (push ? 17'(nl_a) : 17'h0)
                     - (pop ? 17'(nl_b) : 17'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  logic [71:0] kp_a, kp_b, dn_a, dn_b, rd_a_q, rd_b_q, dout_a_q, dout_b_q;
  logic [63:0] pk_a, pk_b;
  wire [143:0] rf_a = mem[row_a] >> sh_a;
  wire [143:0] rf_b = mem[row_b] >> sh_b;
  wire [143:0] wide = is_sp ? rf_a : rf_b;

  // The wide shape splits one row: low half to A, high half to B
  wire [71:0] raw_a = w144 ? wide[71:0] : rf_a[71:0]; // [RULE19]
  wire [71:0] raw_b = w144 ? wide[143:72] : rf_b[71:0]; // [RULE7]
  wire rgo_a = w144 ? (is_sp ? go_a : go_b) : go_a;
  wire rgo_b = w144 ? rgo_a : go_b;

  // Lanes beyond the width read zero; 8-bit modes pack lanes tight
  for (genvar i = 0; i < 8; i++)
  begin : g_rlane
    assign kp_a[9*i+:9] = 5'(i) < nl_a ? raw_a[9*i+:9] : 9'h000;
    assign kp_b[9*i+:9] = w144 || 5'(i) < nl_b ? raw_b[9*i+:9] : 9'h000;
    assign pk_a[8*i+:8] = kp_a[9*i+:8]; // [RULE16]
    assign pk_b[8*i+:8] = kp_b[9*i+:8]; // [RULE16]
  end
  assign dn_a = cfg_q.byte8 ? {8'h00, pk_a} : kp_a;
  assign dn_b = cfg_q.byte8 ? {8'h00, pk_b} : kp_b;

  // Bypass loads the array word straight out; otherwise the output
  // register adds a stage on its own clock enable
  always_ff @(posedge aclk or posedge clr_a)
  begin
    if (clr_a || !aresetn)
    begin
      rd_a_q <= 72'h0; // [RULE24]
      dout_a_q <= 72'h0;
    end
    else
    begin
      if (rgo_a)
        rd_a_q <= dn_a;
      if (!cfg_q.outreg_a && rgo_a)
        dout_a_q <= dn_a; // [RULE5]
      else if (cfg_q.outreg_a && out_en_a)
        dout_a_q <= rd_a_q; // [RULE5] [RULE22]
    end
  end

  always_ff @(posedge aclk or posedge clr_b)
  begin
    if (clr_b || !aresetn)
    begin
      rd_b_q <= 72'h0; // [RULE24]
      dout_b_q <= 72'h0;
    end
    else
    begin
      if (rgo_b)
        rd_b_q <= dn_b;
      if (!cfg_q.outreg_b && rgo_b)
        dout_b_q <= dn_b; // [RULE5]
      else if (cfg_q.outreg_b && out_en_b)
        dout_b_q <= rd_b_q; // [RULE5] [RULE22]
    end
  end

  assign dout_a = dout_a_q;
  assign dout_b = dout_b_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tdp_no_wide_a: assert property (is_tdp |-> !w144 && // [RULE7]
    cfg_q.width_b < `LRAM_W144)
    else $error("144-bit shape in true dual-port mode");
  sdp_pairing_a: assert property (!is_tdp && !is_sp |-> // [RULE8]
    w144 == (cfg_q.width_b == `LRAM_W144))
    else $error("144-bit shape paired with a narrow one");
  cfg_reject_a: assert property (wr_go && wr_cfg && !cand_ok |=> // [RULE7]
    bvalid_q && bresp_q == `LRAM_RESP_SLV && $stable(cfg_q))
    else $error("illegal shape was accepted");
  rd_only_b_a: assert property (!is_tdp |-> !wr_b) // [RULE10]
    else $error("port B wrote outside true dual-port mode");
  narrow_lane_a: assert property (wr_a && cfg_q.width_a == 3'h0 |-> // [RULE12]
    $onehot(le_a))
    else $error("9-bit write did not hit exactly one lane");
  lane_map_a: assert property (wr_a && !w144 && // [RULE13]
    lidx_a[3:0] == 4'h0 |-> wd_a[71:0] == rq_a.din &&
    le_a[7:0] == lm_a[7:0])
    else $error("mask or data lane misplaced");
  wide_mask_a: assert property (wr_a && w144 |-> // [RULE14]
    le_a == {rq_b.mask, rq_a.mask})
    else $error("wide mask not joined from both ports");
  bypass_lat_a: assert property (rgo_a && !cfg_q.outreg_a && !clr_a // [RULE5]
    ##1 !clr_a |-> dout_a_q == $past(dn_a))
    else $error("bypass read not one cycle");
  out_reg_a: assert property (cfg_q.outreg_a && out_en_a && !clr_a // [RULE5]
    ##1 !clr_a |-> dout_a_q == $past(rd_a_q))
    else $error("output register did not load");
  clear_out_a: assert property (clr_a |-> dout_a_q == 72'h0 && // [RULE24]
    rd_a_q == 72'h0)
    else $error("clear left port A registers set");
  fifo_cap_a: assert property (cnt_q <= `LRAM_FIFO_CAP && // [RULE2]
    !(push && full_a))
    else $error("FIFO overfilled");
  byte8_top_a: assert property (rgo_a && cfg_q.byte8 && !clr_a // [RULE16]
    ##1 !clr_a |-> rd_a_q[71:64] == 8'h00)
    else $error("8-bit read left top lane set");

endmodule // lram_top

// file: sim/lram_user.sv
`timescale 1ns/1ps
// Fabric user logic on the far side of both memory ports
module lram_user (
  output logic cen_a,
  output logic clr_a,
  output lram_pkg::lram_req_t req_a,
  output logic cen_b,
  output logic clr_b,
  output lram_pkg::lram_req_t req_b
);
  // Ports start idle with no clear
  initial
  begin
    {cen_a, clr_a, cen_b, clr_b} = 4'h0;
    req_a = '0;
    req_b = '0;
  end

  // Raise a request that stays until rel; dual writes to one
  // address are never issued, their result is undefined
  task automatic op(input bit p, input logic we, input logic [15:0] a,
    input logic [71:0] d, input logic [7:0] m);
    if (!p)
    begin
      cen_a <= 1'h1;
      req_a <= {we, a, d, m};
    end
    else
    begin
      cen_b <= 1'h1;
      req_b <= {we, a, d, m};
    end
  endtask

  // Released lines show inverted data so a stale capture stands out
  task automatic rel(input bit p);
    if (!p)
    begin
      cen_a <= 1'h0;
      req_a <= ~{1'h1, req_a.addr, req_a.din, req_a.mask};
    end
    else
    begin
      cen_b <= 1'h0;
      req_b <= ~{1'h1, req_b.addr, req_b.din, req_b.mask};
    end
  endtask

  // Clear is a level; the memory acts on it without a clock
  task automatic clear(input bit p, input logic v);
    if (!p)
      clr_a <= v;
    else
      clr_b <= v;
  endtask
endmodule // lram_user

// file: sim/lram_top_tb.sv
`timescale 1ns/1ps
`include "lram_cfg.svh"
module lram_top_tb;
  typedef struct {int due; bit [1:0] p; logic [143:0] e, m;} lram_mnote_t;
  typedef struct {bit rd; logic [31:0] d; logic [1:0] r;} lram_anote_t;
  localparam logic [1:0] rsp_ok = `LRAM_RESP_OK;
  localparam logic [1:0] rsp_slv = `LRAM_RESP_SLV;
  localparam logic [31:0] emp = 32'h1 << `LRAM_ST_EMPTY;
  localparam logic [31:0] rej = 32'h1 << `LRAM_ST_REJ;
  localparam logic [143:0] w9 = 144'h1ff;
  localparam logic [143:0] w72 = {72'h0, {72{1'h1}}};
  localparam logic [143:0] w64 = {80'h0, {64{1'h1}}};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cen_a, clr_a, cen_b, clr_b;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  lram_pkg::lram_req_t req_a, req_b;
  logic [71:0] dout_a, dout_b;
  logic [143:0] d1, d2, e;
  logic [15:0] m;
  int cyc, num_errors, n_checks;
  lram_mnote_t mq[$];
  lram_anote_t xq[$];

  always #20 aclk = ~aclk;

  lram_top i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cen_a(cen_a), .clr_a(clr_a), .req_a(req_a), .dout_a(dout_a),
    .cen_b(cen_b), .clr_b(clr_b), .req_b(req_b), .dout_b(dout_b));
  lram_user u_user (.cen_a(cen_a), .clr_a(clr_a), .req_a(req_a),
    .cen_b(cen_b), .clr_b(clr_b), .req_b(req_b));

  //////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic end_sim;
    // Notes never taken off the queues mean a result that never came
    num_errors += mq.size() + xq.size();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_mem(input logic [143:0] o, input lram_mnote_t n);
    n_checks++;
    if ((o & n.m) !== (n.e & n.m))
    begin
      num_errors++;
      $display("MISMATCH %0t port %0d data %h", $time, n.p, o);
    end
  endtask

  task automatic cmp_axi(input logic [31:0] d, input logic [1:0] r,
    input lram_anote_t n);
    n_checks++;
    if (r !== n.r || (n.rd && d !== n.d))
    begin
      num_errors++;
      $display("MISMATCH %0t bus data %h resp %h", $time, d, r);
    end
  endtask

  // Memory results land a fixed count of edges after the request;
  // the cycle counter also cuts a hang short
  always @(posedge aclk)
  begin
    #1;
    cyc++;
    while (mq.size() > 0 && mq[0].due <= cyc)
    begin
      cmp_mem(mq[0].p == 2'h0 ? {72'h0, dout_a} :
        mq[0].p == 2'h1 ? {72'h0, dout_b} : {dout_b, dout_a}, mq[0]);
      void'(mq.pop_front());
    end
    if (cyc > 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // Bus answers are taken at the handshake edge
  always @(posedge aclk)
    if ((bvalid === 1'h1 && bready) || (rvalid === 1'h1 && rready))
    begin
      cmp_axi(rvalid ? rdata : 32'h0,
        rvalid ? rresp : bresp, xq[0]);
      void'(xq.pop_front());
    end

  //////////////////////////////////////////////////////////////////////////
  // Bus master and port drivers
  task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
    xq.push_back('{1'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [31:0] a, d, input logic [1:0] r);
    xq.push_back('{1'h1, d, r});
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arready === 1'h1)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic mw(input bit p, input logic [15:0] a,
    input logic [71:0] d, input logic [7:0] k);
    u_user.op(p, 1'h1, a, d, k);
    @(posedge aclk);
    u_user.rel(p);
    @(posedge aclk);
  endtask

  // Reads offer live data and mask, which must not be written;
  // cyc still counts up to the edge before the launching one
  task automatic mr(input bit [1:0] p, input logic [15:0] a,
    input logic [143:0] x, k, input int lat);
    mq.push_back('{cyc + 1 + lat, p, x, k});
    u_user.op(p != 2'h0, 1'h0, a, ~x[71:0], 8'hff);
    @(posedge aclk);
    u_user.rel(p != 2'h0);
    @(posedge aclk);
  endtask

  task automatic w144(input logic [143:0] d, input logic [15:0] k);
    u_user.op(1'b0, 1'h1, 16'h5, d[71:0], k[7:0]);
    u_user.op(1'b1, 1'h0, 16'h5, d[143:72], k[15:8]);
    @(posedge aclk);
    u_user.rel(1'b0);
    u_user.rel(1'b1);
    @(posedge aclk);
  endtask

  function automatic logic [143:0] rnd();
    return {16'($urandom), $urandom, $urandom, $urandom, $urandom};
  endfunction

  // Lanes whose mask bit is set take new data, the rest keep old
  function automatic logic [143:0] mrg(logic [143:0] o, n,
    logic [15:0] k, int lw);
    mrg = o;
    for (int b = 0; b < 16 * lw; b++)
      if (k[b / lw])
        mrg[b] = n[b];
  endfunction

  function automatic logic [31:0] cf(logic [1:0] md, logic [2:0] wa, wb,
    logic [6:0] fl);
    return {17'h0, fl, wb, wa, md};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    void'($urandom(32'h107c));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(`LRAM_CFG_OFF, 32'h0, rsp_ok);
    axr(32'h8, 32'h0, rsp_slv);
    axw(32'h8, 32'h5, rsp_slv);
    axw(`LRAM_STAT_OFF, 32'hffff_ffff, rsp_ok);
    axr(`LRAM_STAT_OFF, emp, rsp_ok);
    axw(`LRAM_CFG_OFF, cf(2'h0, 3'h4, 3'h0, 7'h0), rsp_slv);
    axw(`LRAM_CFG_OFF, cf(2'h1, 3'h4, 3'h3, 7'h0), rsp_slv);
    axr(`LRAM_CFG_OFF, 32'h0, rsp_ok);
    axr(`LRAM_STAT_OFF, emp | rej, rsp_ok);
    // Mixed widths: 72-bit port A against 9-bit port B
    axw(`LRAM_CFG_OFF, cf(2'h0, 3'h3, 3'h0, 7'h0), rsp_ok);
    d1 = rnd();
    d2 = rnd();
    m = {8'h0, 1'h0, 6'($urandom), 1'h1};
    mw(1'b0, 16'h1, d1[71:0], 8'hff);
    for (int i = 0; i < 8; i++)
      mr(2'h1, 16'(8 + i), d1 >> (9 * i), w9, 2);
    mw(1'b0, 16'h1, d2[71:0], m[7:0]);
    e = mrg(d1, d2, m, 9);
    mr(2'h0, 16'h1, e, w72, 2);
    mw(1'b1, 16'h9, 72'h0ab, 8'hff);
    e[17:9] = 9'h0ab;
    mr(2'h0, 16'h1, e, w72, 2);
    // Clear empties port registers at once and spares the array;
    // one edge first so the last read result is still compared
    @(posedge aclk);
    u_user.clear(1'b0, 1'h1);
    #1;
    cmp_mem({72'h0, dout_a}, '{0, 2'h0, 144'h0, w72});
    @(posedge aclk);
    u_user.clear(1'b0, 1'h0);
    @(posedge aclk);
    // Output register on port A, enabled by port B's clock enable
    axw(`LRAM_CFG_OFF, cf(2'h0, 3'h3, 3'h0, 7'h11), rsp_ok);
    u_user.op(1'b1, 1'h0, 16'h0, 72'h0, 8'h0);
    mq.push_back('{cyc + 3, 2'h0, 144'h0, w72});
    mr(2'h0, 16'h1, e, w72, 3);
    // Port B's enable must stand one more edge to load the output stage
    @(posedge aclk);
    u_user.rel(1'b1);
    @(posedge aclk);
    // Eight-bit lanes
    axw(`LRAM_CFG_OFF, cf(2'h0, 3'h3, 3'h3, 7'h04), rsp_ok);
    mw(1'b0, 16'h2, d1[71:0], 8'hff);
    mw(1'b0, 16'h2, d2[71:0], m[7:0]);
    mr(2'h1, 16'h2, mrg(d1, d2, m, 8), w64, 2);
    // Widest shape: both masks joined into sixteen lanes
    axw(`LRAM_CFG_OFF, cf(2'h1, 3'h4, 3'h4, 7'h0), rsp_ok);
    d1 = rnd();
    d2 = rnd();
    m = 16'($urandom) | 16'h8000;
    w144(d1, 16'hffff);
    w144(d2, m);
    mr(2'h2, 16'h5, mrg(d1, d2, m, 9), {144{1'h1}}, 2);
    // First in, first out with lane count in status
    axw(`LRAM_CFG_OFF, cf(2'h3, 3'h0, 3'h0, 7'h0), rsp_ok);
    for (int i = 0; i < 3; i++)
      mw(1'b0, 16'h0, 72'(d1 >> (9 * i)), 8'hff);
    axr(`LRAM_STAT_OFF, 32'h3, rsp_ok);
    for (int i = 0; i < 3; i++)
      mr(2'h1, 16'h0, d1 >> (9 * i), w9, 2);
    axr(`LRAM_STAT_OFF, emp, rsp_ok);
    // Single port
    axw(`LRAM_CFG_OFF, cf(2'h2, 3'h3, 3'h0, 7'h0), rsp_ok);
    mw(1'b0, 16'h7, d2[71:0], 8'hff);
    mr(2'h0, 16'h7, d2, w72, 2);
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule // lram_top_tb
